// ---- logic/spi_hosted_uart_core.sv ----
// character fifo and the host-driven uart core
// assumes all pins are asynchronous; host shift clock far below core clock
`default_nettype none

// ==========================================================
// generic fifo, state in flip-flops
module char_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
    } fifo_s;

    fifo_s s_r;
    fifo_s s_nxt;
    logic push;
    logic pop;

    assign in_ready = (s_r.count != CNT_FULL);
    assign out_valid = (s_r.count != '0);
    assign out_data = s_r.mem[s_r.rd];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        s_nxt = s_r;
        if (push)
        begin
            s_nxt.mem[s_r.wr] = in_data;
            s_nxt.wr = (s_r.wr == PTR_LAST) ? '0 : s_r.wr + 1'b1;
        end
        if (pop)
            s_nxt.rd = (s_r.rd == PTR_LAST) ? '0 : s_r.rd + 1'b1;
        if (push && !pop)
            s_nxt.count = s_r.count + 1'b1;
        else if (pop && !push)
            s_nxt.count = s_r.count - 1'b1;
        if (srst)
            s_nxt = '0;
    end

    always_ff @(posedge clock)
        s_r <= s_nxt;
endmodule

// ==========================================================
// uart core behind the host serial port
module spi_hosted_uart_core
    import uart_core_pkg::*;
#(
    parameter int BASE_TICK = TICK_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe_n,
    input wire logic rx,
    output logic tx,
    input wire logic cts_n,
    output logic cts_status,
    output logic rx_avail,
    output logic framing_fault_flag,
    output logic addr_char_irq,
    output logic [3:0] baud_divisor_sel
);
    typedef struct packed {
        logic sclk_m, sclk_s, sclk_d;
        logic cs_m, cs_s, cs_d;
        logic din_m, din_s;
        logic rx_m, rx_s;
        logic cts_m, cts_s, cts_status;
        logic [4:0] cnt;
        logic [15:0] in_sh;
        logic [15:0] out_sh;
        logic [1:0] op;
        logic had_data;
        logic dout, dout_oe_n;
        cfg_s cfg;
        logic fe, irq, avail;
        logic [7:0] tick_cnt;
        logic tick;
        rx_state_e rx_state;
        logic [3:0] rx_sub, rx_idx;
        logic [8:0] rx_bits;
        logic [4:0] ir_hold;
        tx_state_e tx_state;
        logic [3:0] tx_sub, tx_idx;
        char_s tx_word;
        logic tx_line;
    } core_s;

    core_s s_r;
    core_s s_nxt;

    // ==========================================================
    // frame field packing, shared by logic and checks
    function automatic cfg_s cfg_from_word(input logic [15:0] w);
        cfg_s c;
        c.fifo_disable_n = w[BIT_FEN];
        c.infrared_timing_sel = w[BIT_IR];
        c.extra_bit_enable = w[BIT_PE];
        c.word_short = w[BIT_L];
        c.baud_divisor_sel = w[BAUD_LSB +: 4];
        return c;
    endfunction

    function automatic logic [7:0] fit_byte(input logic [7:0] b,
                                            input logic short_w);
        return short_w ? {1'b0, b[6:0]} : b;
    endfunction

    logic sclk_rise, sclk_fall, cs_fall, cs_rise, frame, full;
    logic rx_line, rx_push, rx_accept, rx_pop, rx_valid, rx_fin_ready;
    logic tx_push, tx_ready, tx_valid, tx_pop, tx_bit, fe_set, fe_clr;
    logic [3:0] n_data, n_bits;
    logic [7:0] tick_reload;
    char_s rx_char, rx_head, tx_char, tx_head;
    logic [15:0] data_word, cfg_word;

    assign sclk_rise = s_r.sclk_s & ~s_r.sclk_d;
    assign sclk_fall = ~s_r.sclk_s & s_r.sclk_d;
    assign cs_fall = ~s_r.cs_s & s_r.cs_d;
    assign cs_rise = s_r.cs_s & ~s_r.cs_d;
    assign frame = ~s_r.cs_s;
    assign full = (s_r.cnt == FRAME_BITS);
    assign n_data = s_r.cfg.word_short ? SHORT_BITS : LONG_BITS;
    assign n_bits = n_data + {3'h0, s_r.cfg.extra_bit_enable};
    assign tick_reload = 8'((32'(s_r.cfg.baud_divisor_sel) + 1) * BASE_TICK
                            - 1);
    assign rx_line = s_r.cfg.infrared_timing_sel ? (s_r.ir_hold == '0)
                                                 : s_r.rx_s;

    assign rx_char.extra = s_r.cfg.extra_bit_enable & s_r.rx_bits[n_data];
    assign rx_char.data = fit_byte(s_r.rx_bits[7:0], s_r.cfg.word_short);
    assign rx_push = (s_r.rx_state == RX_STOP) && s_r.tick &&
                     (s_r.rx_sub == SUB_LAST) && rx_line;
    assign rx_accept = rx_push & (~s_r.cfg.fifo_disable_n | ~rx_valid);
    assign fe_set = (s_r.rx_state == RX_STOP) && s_r.tick &&
                    (s_r.rx_sub == SUB_LAST) && !rx_line;
    assign rx_pop = frame && sclk_fall && full && !s_r.op[0] && s_r.had_data;
    assign tx_push = cs_rise && full && (s_r.op == OP_DATA_WR);
    // top bit dropped for short words
    assign tx_char.data = fit_byte(s_r.in_sh[7:0], s_r.cfg.word_short);
    assign tx_char.extra = s_r.in_sh[BIT_EXTRA];
    assign fe_clr = rx_push | (cs_rise && full && (s_r.op == OP_CFG_WR));
    assign tx_pop = (s_r.tx_state == TX_IDLE) && s_r.tick && tx_valid;
    assign tx_bit = (s_r.tx_idx < n_data) ? s_r.tx_word.data[s_r.tx_idx[2:0]]
                                         : s_r.tx_word.extra;

    always_comb
    begin
        data_word = '0;
        data_word[BIT_R] = rx_valid;
        data_word[BIT_T] = tx_ready;
        data_word[BIT_FE] = s_r.fe;
        data_word[BIT_CTS] = s_r.cts_status;
        if (rx_valid)
        begin
            data_word[BIT_EXTRA] = rx_head.extra;
            data_word[7:0] = fit_byte(rx_head.data, s_r.cfg.word_short);
        end
        cfg_word = '0;
        cfg_word[BIT_R] = rx_valid;
        cfg_word[BIT_T] = tx_ready;
        cfg_word[BIT_FEN] = s_r.cfg.fifo_disable_n;
        cfg_word[BIT_IR] = s_r.cfg.infrared_timing_sel;
        cfg_word[BIT_PE] = s_r.cfg.extra_bit_enable;
        cfg_word[BIT_L] = s_r.cfg.word_short;
        cfg_word[BAUD_LSB +: 4] = s_r.cfg.baud_divisor_sel;
    end

    char_fifo #(.WIDTH(CHAR_W), .DEPTH(RX_DEPTH)) rx_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(rx_accept),
        .in_ready(rx_fin_ready),
        .in_data(rx_char),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_head)
    );

    // transmitter pops only in TX_IDLE, so the fifo backs up into T
    char_fifo #(.WIDTH(CHAR_W), .DEPTH(TX_DEPTH)) tx_fifo (
        .clock(clock),
        .srst(srst),
        .in_valid(tx_push),
        .in_ready(tx_ready),
        .in_data(tx_char),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_head)
    );

    always_comb
    begin
        core_s rst_v;
        rst_v = '0;
        s_nxt = s_r;
        // ==========================================================
        // two-stage synchronisers, third stage only for edges
        s_nxt.sclk_m = sclk;
        s_nxt.sclk_s = s_r.sclk_m;
        s_nxt.sclk_d = s_r.sclk_s;
        s_nxt.cs_m = cs_n;
        s_nxt.cs_s = s_r.cs_m;
        s_nxt.cs_d = s_r.cs_s;
        s_nxt.din_m = din;
        s_nxt.din_s = s_r.din_m;
        s_nxt.rx_m = rx;
        s_nxt.rx_s = s_r.rx_m;
        s_nxt.cts_m = cts_n;
        s_nxt.cts_s = s_r.cts_m;
        s_nxt.cts_status = ~s_r.cts_s;

        // ==========================================================
        // host port, mode 0 only
        // idle-low clock, leading-edge sample
        if (cs_fall)
        begin
            s_nxt.cnt = '0;
            s_nxt.out_sh = data_word;
            s_nxt.had_data = rx_valid;
        end
        else if (frame)
        begin
            if (sclk_rise && !full)
            begin
                s_nxt.in_sh = {s_r.in_sh[14:0], s_r.din_s};
                s_nxt.cnt = s_r.cnt + 1'b1;
                if (s_r.cnt == OP_BITS)
                begin
                    s_nxt.op = {s_r.in_sh[0], s_r.din_s};
                    if ({s_r.in_sh[0], s_r.din_s} == OP_CFG_RD)
                        s_nxt.out_sh[14:1] = cfg_word[13:0];
                end
            end
            if (sclk_fall)
                s_nxt.out_sh = {s_r.out_sh[14:0], 1'b0};
        end
        if (cs_rise && full && (s_r.op == OP_CFG_WR))
            s_nxt.cfg = cfg_from_word(s_r.in_sh);
        s_nxt.dout = s_nxt.out_sh[15];
        s_nxt.dout_oe_n = s_r.cs_s;

        s_nxt.fe = fe_set | (s_r.fe & ~fe_clr);
        s_nxt.irq = s_r.cfg.extra_bit_enable & rx_valid & rx_head.extra;
        s_nxt.avail = rx_valid;

        // ==========================================================
        // oversampling tick
        // rate from divisor select
        s_nxt.tick = (s_r.tick_cnt == '0);
        s_nxt.tick_cnt = (s_r.tick_cnt == '0) ? tick_reload
                                             : s_r.tick_cnt - 1'b1;
        if (s_r.cfg.infrared_timing_sel && s_r.rx_s)
            s_nxt.ir_hold = IR_HOLD_SUBS;
        else if (s_r.tick && s_r.ir_hold != '0)
            s_nxt.ir_hold = s_r.ir_hold - 1'b1;

        // ==========================================================
        // receiver
        case (s_r.rx_state)
            RX_IDLE:
                if (!rx_line)
                begin
                    s_nxt.rx_state = RX_START;
                    s_nxt.rx_sub = '0;
                end
            RX_START:
                if (s_r.tick)
                begin
                    s_nxt.rx_sub = s_r.rx_sub + 1'b1;
                    if (s_r.rx_sub == SUB_MID)
                    begin
                        s_nxt.rx_state = rx_line ? RX_IDLE : RX_BITS;
                        s_nxt.rx_sub = '0;
                        s_nxt.rx_idx = '0;
                        s_nxt.rx_bits = '0;
                    end
                end
            RX_BITS:
                if (s_r.tick)
                begin
                    s_nxt.rx_sub = s_r.rx_sub + 1'b1;
                    if (s_r.rx_sub == SUB_LAST)
                    begin
                        s_nxt.rx_bits[s_r.rx_idx] = rx_line;
                        s_nxt.rx_idx = s_r.rx_idx + 1'b1;
                        if (s_r.rx_idx == n_bits - 1'b1)
                            s_nxt.rx_state = RX_STOP;
                    end
                end
            RX_STOP:
                if (s_r.tick)
                begin
                    s_nxt.rx_sub = s_r.rx_sub + 1'b1;
                    // either way, hunt for next start
                    if (s_r.rx_sub == SUB_LAST)
                        s_nxt.rx_state = RX_IDLE;
                end
            default:
                s_nxt.rx_state = RX_IDLE;
        endcase

        // ==========================================================
        // transmitter
        case (s_r.tx_state)
            TX_IDLE:
            begin
                s_nxt.tx_line = ~s_r.cfg.infrared_timing_sel;
                if (tx_pop)
                begin
                    s_nxt.tx_word = tx_head;
                    s_nxt.tx_state = TX_START;
                    s_nxt.tx_sub = '0;
                end
            end
            TX_START, TX_BITS, TX_STOP:
            begin
                s_nxt.tx_line = (s_r.tx_state == TX_BITS) ? tx_bit
                                : (s_r.tx_state == TX_STOP);
                // short high pulse marks a zero
                if (s_r.cfg.infrared_timing_sel)
                    s_nxt.tx_line = ~s_nxt.tx_line &
                                    (s_r.tx_sub < IR_PULSE_SUBS);
                if (s_r.tick)
                begin
                    s_nxt.tx_sub = s_r.tx_sub + 1'b1;
                    if (s_r.tx_sub == SUB_LAST)
                    begin
                        s_nxt.tx_idx = s_r.tx_idx + 1'b1;
                        if (s_r.tx_state == TX_START)
                        begin
                            s_nxt.tx_state = TX_BITS;
                            s_nxt.tx_idx = '0;
                        end
                        else if (s_r.tx_state == TX_STOP)
                            s_nxt.tx_state = TX_IDLE;
                        else if (s_r.tx_idx == n_bits - 1'b1)
                            s_nxt.tx_state = TX_STOP;
                    end
                end
            end
            default:
                s_nxt.tx_state = TX_IDLE;
        endcase

        // clear-to-send path survives reset on purpose
        if (srst)
        begin
            rst_v.sclk_m = 1'b0;
            rst_v.cs_m = 1'b1;
            rst_v.cs_s = 1'b1;
            rst_v.cs_d = 1'b1;
            rst_v.dout_oe_n = 1'b1;
            rst_v.tx_line = 1'b1;
            rst_v.cts_m = s_nxt.cts_m;
            rst_v.cts_s = s_nxt.cts_s;
            rst_v.cts_status = s_nxt.cts_status;
            s_nxt = rst_v;
        end
    end

    always_ff @(posedge clock)
        s_r <= s_nxt;

    assign dout = s_r.dout;
    assign dout_oe_n = s_r.dout_oe_n;
    assign tx = s_r.tx_line;
    assign cts_status = s_r.cts_status;
    assign rx_avail = s_r.avail;
    assign framing_fault_flag = s_r.fe;
    assign addr_char_irq = s_r.irq;
    assign baud_divisor_sel = s_r.cfg.baud_divisor_sel;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    AST_CNT_RESTART: assert property (cs_fall |=> s_r.cnt == '0)
        else $error("bit counter not cleared at select fall");
    AST_MSB_FIRST: assert property (cs_fall |=> ##1 dout == $past(data_word[15], 2))
        else $error("msb not driven after select fall");
    AST_SHIFT_FALL: assert property (frame && sclk_fall && !cs_fall |=> ##1 dout == $past(s_r.out_sh[14], 2))
        else $error("output bit did not advance on falling edge");
    AST_CAPTURE: assert property (frame && sclk_rise && !full && !cs_fall |=> s_r.in_sh[0] == $past(s_r.din_s))
        else $error("input bit not captured on rising edge");
    AST_ABORT: assert property (cs_rise && !full |=> $stable(s_r.cfg))
        else $error("short frame changed configuration");
    AST_CFG_COMMIT: assert property (cs_rise && full && s_r.op == OP_CFG_WR |=> s_r.cfg == cfg_from_word($past(s_r.in_sh)))
        else $error("configuration not committed at select rise");
    AST_SIXTEEN: assert property (s_r.cnt <= FRAME_BITS)
        else $error("frame counter beyond sixteen");
    AST_CTS: assert property ($stable(cts_n)[*4] |-> cts_status == !cts_n)
        else $error("clear-to-send status not inverted pin");
    AST_SHORT_RX: assert property (rx_accept && s_r.cfg.word_short |-> !rx_char.data[7])
        else $error("short word stored with top bit set");
    AST_EXTRA_ZERO: assert property (rx_accept && !s_r.cfg.extra_bit_enable |-> !rx_char.extra)
        else $error("extra bit stored while disabled");
    AST_FE_SET: assert property (fe_set |=> framing_fault_flag ##1 framing_fault_flag || $past(fe_clr))
        else $error("framing fault not flagged");
    AST_POP: assert property (
        rx_pop |=> ##1 rx_avail == $past(rx_valid))
        else $error("receive available mishandled");

    COV_CFG_WR: cover property (cs_rise && full && s_r.op == OP_CFG_WR);
    COV_DATA_WR: cover property (tx_push && tx_ready);
    COV_RX_EXTRA: cover property (rx_accept && rx_char.extra);
    COV_ABORT: cover property (cs_rise && !full && s_r.cnt != '0);
endmodule

`default_nettype wire

// ---- logic/uart_core_pkg.sv ----
// constants, carrier types and states of the host-driven uart core
// assumes a 50 MHz core clock; every pin is asynchronous to it
// Function
// - host port works only with clock idle low, sampling on leading edge
// - async and infrared streams up to 230 kbaud, eight-entry receive fifo
// - flag an interrupt source when an address character carries extra bit
// - every frame shifts exactly sixteen bits in and sixteen bits out
// - first two input bits choose config write/read or data write/read
// - capture each input bit on the rising shift clock edge
// - msb appears at select fall, later bits change on falling clock edges
// - select released before sixteen bits abandons frame, nothing changes
// - register updates and clears happen when select rises after full frame; receive fifo pops at sixteenth clock fall instead
// - each select fall restarts the bit counter for a fresh frame
// - four-bit baud divisor select, written and read back, resets to zero
// - clear-to-send status is inverted pin, untouched by reset
// - data write loads eight bits, top bit dropped for short words
// - data read returns fifo byte, zero after reset, top bit zero if short
// - fifo enabled when active-low control is zero, bypassed when one
// - infrared select switches line to pulse timing, reads back
// - word-length bit picks eight or seven bits, plus extra when enabled
// - extra transmit bit sent as written when enabled, no parity computed
// - received extra bit stored with its character, zero when disabled
// - extra-bit enable resets to zero, adds one bit each direction
// - receive-available clears at sixteenth clock fall if nothing pending
// - zero at first stop bit flags framing fault, next good char clears it
`default_nettype none

package uart_core_pkg;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MAX_BAUD = 230_400;
    localparam int OVERSAMPLE = 16;
    // subtick period rounded up so the top rate never exceeds the limit
    localparam int TICK_CYCLES =
        (CLK_HZ + MAX_BAUD * OVERSAMPLE - 1) / (MAX_BAUD * OVERSAMPLE);
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [3:0] IR_PULSE_SUBS = 4'h3;
    localparam logic [4:0] IR_HOLD_SUBS = 5'h10;

    // ==========================================================
    // host frame
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] OP_BITS = 5'h01;
    localparam logic [1:0] OP_CFG_WR = 2'h3;
    localparam logic [1:0] OP_CFG_RD = 2'h1;
    localparam logic [1:0] OP_DATA_WR = 2'h2;
    localparam logic [1:0] OP_DATA_RD = 2'h0;
    localparam int BIT_R = 15;
    localparam int BIT_T = 14;
    localparam int BIT_FEN = 13;
    localparam int BIT_FE = 10;
    localparam int BIT_CTS = 9;
    localparam int BIT_EXTRA = 8;
    localparam int BIT_IR = 7;
    localparam int BIT_PE = 5;
    localparam int BIT_L = 4;
    localparam int BAUD_LSB = 0;

    // ==========================================================
    // character and fifo
    localparam int RX_DEPTH = 8;
    localparam int TX_DEPTH = 16;
    localparam logic [3:0] LONG_BITS = 4'h8;
    localparam logic [3:0] SHORT_BITS = 4'h7;

    typedef struct packed {
        logic fifo_disable_n;
        logic infrared_timing_sel;
        logic extra_bit_enable;
        logic word_short;
        logic [3:0] baud_divisor_sel;
    } cfg_s;

    typedef struct packed {
        logic extra;
        logic [7:0] data;
    } char_s;

    localparam int CHAR_W = $bits(char_s);

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_e;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_state_e;

endpackage

`default_nettype wire

// ---- tb/spi_host_model.sv ----
// host shift-port model: mode 0 master, sixteen-bit frames
// assumes one transfer at a time, started off a clock fall
`default_nettype none
module spi_host_model (
    input wire logic clock,
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // ====================
    // transfer
    // n below 16 aborts
    task automatic xfer(input logic [15:0] w, input int n,
        output logic [15:0] r);
        cs_n = 1'b0;
        repeat (8) @(negedge clock);
        for (int i = 0; i < n; i++)
        begin
            din = w[15 - i];
            repeat (4) @(negedge clock);
            r[15 - i] = dout;
            sclk = 1'b1;
            repeat (4) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        // released line must not keep its value
        din = ~din;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// ---- tb/spi_hosted_uart_core_test.sv ----
// bench: host model, line driver and checks for the uart core
// assumes BASE_TICK 1 and divisor select zero, so one line bit lasts sixteen core clocks
`default_nettype none
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            miscompares++; \
            $display("ERROR %0t got %h exp %h", $time, a, b); \
        end \
    end
module spi_hosted_uart_core_test
    import uart_core_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, srst = 1'b1, rx = 1'b1, cts_n = 1'b1;
    wire logic sclk, cs_n, din, dout, oe_n, tx, cts, avail, fault, irq;
    wire logic [3:0] baud;
    int miscompares = 0, samples_checked = 0;
    logic [31:0] seed = 32'h4ac4;
    logic [15:0] r;
    logic [11:0] f;
    logic [7:0] b;
    logic x;
    always #10 clock = ~clock;
    spi_host_model host (.clock(clock), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout));
    spi_hosted_uart_core #(.BASE_TICK(1)) DUT (.clock(clock), .srst(srst),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe_n(oe_n),
        .rx(rx), .tx(tx), .cts_n(cts_n), .cts_status(cts),
        .rx_avail(avail), .framing_fault_flag(fault), .addr_char_irq(irq),
        .baud_divisor_sel(baud));
    // ====================
    // helpers
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // line frame, lsb first, idle ones past the stop bit
    function automatic logic [11:0] frame(logic [7:0] d, logic e,
        logic sh, logic pe, logic stp);
        logic [11:0] v;
        int n;
        v = 12'hffe;
        n = sh ? 7 : 8;
        for (int i = 0; i < n; i++)
            v[1 + i] = d[i];
        if (pe)
            v[1 + n] = e;
        v[1 + n + pe] = stp;
        return v;
    endfunction
    task automatic stop_test();
        $display("TB: %0d errors, %0d checks", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cfg(input logic [15:0] w);
        host.xfer(w, 16, r);
        host.xfer(16'h4000, 16, r);
        `CHK(r[13:0] & 14'h20bf, w[13:0] & 14'h20bf)
        `CHK(baud, w[3:0])
    endtask
    task automatic send_rx(input logic [11:0] v);
        for (int i = 0; i < 12; i++)
        begin
            rx = v[i];
            repeat (16) @(negedge clock);
        end
    endtask
    task automatic get_tx(output logic [11:0] v);
        int k;
        for (k = 0; k < 300 && tx !== 1'b0; k++)
            @(negedge clock);
        if (k == 300)
        begin
            miscompares++;
            stop_test();
        end
        repeat (8) @(negedge clock);
        for (int i = 0; i < 12; i++)
        begin
            v[i] = tx;
            repeat (16) @(negedge clock);
        end
    endtask
    // ====================
    // main sequence
    initial
    begin
        repeat (10) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        `CHK({baud, avail, fault, tx, oe_n}, 8'h03)
        host.xfer(16'h0000, 16, r);
        `CHK({r[15:14], r[7:0]}, 10'h100)
        for (int k = 0; k < 4; k++)
        begin
            seed = lfsr(seed);
            cts_n = seed[20];
            // infrared idles low: lower the line first
            if (seed[7])
                rx = 1'b0;
            cfg({2'h3, seed[13:0]});
            rx = ~seed[7];
            `CHK(cts, ~cts_n)
        end
        host.xfer(16'hffff, 9, r);
        host.xfer(16'h4000, 16, r);
        `CHK(r[13:0] & 14'h20bf, seed[13:0] & 14'h20bf)
        for (int k = 0; k < 2; k++)
        begin
            cfg(k ? 16'hc010 : 16'hc020);
            rx = 1'b1;
            // let noise characters from earlier modes finish
            repeat (600) @(negedge clock);
            for (int j = 0; j < 9 && avail === 1'b1; j++)
                host.xfer(16'h0000, 16, r);
            seed = lfsr(seed);
            b = seed[7:0];
            x = seed[8] | (k == 0);
            host.xfer({7'h40, x, b}, 16, r);
            get_tx(f);
            `CHK(f, frame(b, x, k[0], !k, 1'b1))
            send_rx(frame(b, x, k[0], !k, 1'b0));
            `CHK({fault, avail}, 2'h2)
            send_rx(frame(b, x, k[0], !k, 1'b1));
            `CHK({fault, avail, irq}, {2'h1, !k})
            host.xfer(16'h0000, 16, r);
            `CHK(r & 16'h81ff, {7'h40, x & !k, b & {!k, 7'h7f}})
            `CHK(avail, 1'b0)
        end
        stop_test();
    end
endmodule
`default_nettype wire
